/* design/pmbc_pkg.sv */
// Package for the power mode and brown-out controller.
// Assumes a single 25 MHz core clock domain.
package pmbc_pkg;
   // Register byte addresses (word aligned, word index in address[4:2])
   localparam logic [4:0] ADDR_MODE  = 5'h00;
   localparam logic [4:0] ADDR_FLAGS = 5'h04;
   localparam logic [4:0] ADDR_BOD   = 5'h08;
   localparam logic [4:0] ADDR_WAKE  = 5'h0C;
   localparam logic [4:0] ADDR_STAT  = 5'h10;
   // Mode register fields
   localparam int MODE_IDLE  = 0;
   localparam int MODE_PD    = 1;
   localparam int MODE_DIV_L = 2;
   localparam int MODE_OSC_L = 5;
   // Flag register fields
   localparam int FLG_WDT  = 0;
   localparam int FLG_FIX  = 1;
   localparam int FLG_SEL  = 2;
   // Brown-out control fields
   localparam int BOD_FIX_RE = 1;
   localparam int BOD_SEL_EN = 2;
   localparam int BOD_SEL_RE = 3;
   localparam int BOD_THR_L  = 4;
   localparam int BOD_ALIVE  = 8;
   localparam int BOD_SFIE   = 9;
   localparam int BOD_FIXIE  = 10;
   localparam int BOD_SELIE  = 11;
   // Wake control fields
   localparam int WK_EXT_L  = 0;
   localparam int WK_KBD    = 4;
   localparam int WK_WDTEN  = 5;
   localparam int WK_NSW    = 6;
   localparam int WK_WDTRE  = 7;
   localparam int WK_POL_L  = 8;
   // Reset values
   localparam logic [11:0] BOD_RST  = 12'h000;
   localparam logic [11:0] WAKE_RST = 12'h000;
   localparam logic [6:0]  MODE_RST = 7'h00;
   // Low-speed RC source code in the oscillator select field
   localparam logic [1:0]  OSC_LOW_RC = 2'h1;
   // Timing
   localparam int CLK_HZ        = 25_000_000;
   localparam int WAKE_TMO_DEF  = 1024;
   // Threshold codes, in tenths of a volt
   localparam logic [5:0] THR_2V0 = 6'h14;
   localparam logic [5:0] THR_2V4 = 6'h18;
   localparam logic [5:0] THR_3V7 = 6'h25;
   localparam logic [5:0] THR_4V2 = 6'h2A;
   localparam logic [5:0] THR_FIX = 6'h16;
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_IDLE = 2'b01,
      ST_PD   = 2'b11,
      ST_WAKE = 2'b10
   } pmbc_state_t;
endpackage

/* design/pmbc_ctrl.sv */
// Power mode and brown-out controller: flags, resets, idle, power-down, wake timer.
// Assumes analog detectors give supply level in tenths of a volt, synchronous.
`timescale 1ns/1ns
module pmbc_ctrl
   import pmbc_pkg::*;
#(
   parameter int WAKE_TMO = WAKE_TMO_DEF
)(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // Avalon-MM slave
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Supply level and events
   input  wire logic [5:0]  VDD_LEVEL,
   input  wire logic [3:0]  EXT_IRQ,
   input  wire logic [3:0]  EXT_IRQ_EDGE,
   input  wire logic        KEYPAD_MATCH,
   input  wire logic        RESET_PIN,
   input  wire logic        WDT_OVERFLOW,
   input  wire logic        CPU_IRQ_PENDING,
   // Controls to the core
   output logic             CPU_CLK_EN,
   output logic             OSC_EN,
   output logic             FLASH_PWR_EN,
   output logic             SLOW_MODE,
   output logic             SUBCLK_MODE,
   output logic [2:0]       SYSCLK_DIV_SEL,
   output logic [1:0]       OSC_SOURCE_SEL,
   output logic             WDT_RUN,
   output logic             SYS_FLAG_IRQ,
   output logic             SYS_RESET
);

////////////////////////////////////////////////////////////////////////////////
   localparam int CNT_W = $clog2(WAKE_TMO + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WAKE_TMO - 1);

   pmbc_state_t      state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [6:0]       mode_r, mode_nxt;
   logic [2:0]       flag_r, flag_nxt;
   logic [11:0]      bod_r, bod_nxt;
   logic [11:0]      wake_r, wake_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             rst_r, rst_nxt;
   logic             rpin_r, rpin_nxt;
   logic             ack_r, ack_nxt;

   logic [5:0] thr;
   logic       fix_evt, sel_evt, sel_live, wd_run;
   logic       irq_wake, rst_wake, wake_any, reset_req;
   logic [3:0] ext_lvl;
   logic       wr, rd;

   assign wr = AVS_WRITE && !ack_r;
   assign rd = AVS_READ && !ack_r;

   always_comb begin
      case (bod_r[BOD_THR_L +: 2])
         2'b00:   thr = THR_2V0;
         2'b01:   thr = THR_2V4;
         2'b10:   thr = THR_3V7;
         default: thr = THR_4V2;
      endcase
   end

   // Selectable detector is powered in run/idle when enabled, in power-down only if alive
   assign sel_live = bod_r[BOD_SEL_EN] &&
                     ((state_r != ST_PD) || bod_r[BOD_ALIVE]);
   assign fix_evt  = (state_r != ST_PD) && (VDD_LEVEL <= THR_FIX);
   assign sel_evt  = sel_live && (VDD_LEVEL <= thr);
   assign wd_run   = wake_r[WK_WDTEN] &&
                     ((state_r != ST_PD) || wake_r[WK_NSW]);

   // Edge-configured inputs act as levels of chosen polarity in power-down
   assign ext_lvl  = (EXT_IRQ ~^ wake_r[WK_POL_L +: 4]) & wake_r[WK_EXT_L +: 4];

   always_comb begin
      irq_wake = |ext_lvl
              || (KEYPAD_MATCH && wake_r[WK_KBD])
              || (sel_evt && bod_r[BOD_SELIE] && bod_r[BOD_SFIE])
              || (WDT_OVERFLOW && wd_run && !wake_r[WK_WDTRE]);
      rst_wake = (sel_evt && bod_r[BOD_SEL_RE])
              || (WDT_OVERFLOW && wd_run && wake_r[WK_WDTRE]);
      wake_any = irq_wake || rst_wake || (RESET_PIN && !rpin_r);
   end

   assign reset_req = (fix_evt && bod_r[BOD_FIX_RE])
                   || (sel_evt && bod_r[BOD_SEL_RE])
                   || (WDT_OVERFLOW && wd_run && wake_r[WK_WDTRE]);

////////////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_RUN: begin
            if (mode_r[MODE_PD]) begin
               state_nxt = ST_PD;
            end else if (mode_r[MODE_IDLE]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (CPU_IRQ_PENDING || reset_req || !mode_r[MODE_IDLE]) begin
               state_nxt = ST_RUN;
            end
         end
         ST_PD: begin
            if (wake_any) begin
               state_nxt = ST_WAKE;
               cnt_nxt   = '0;
            end
         end
         ST_WAKE: begin
            if (cnt_r == CNT_FULL) begin
               state_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r + CNT_W'(1);
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_r <= ST_RUN;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Register file and flags
   always_comb begin
      mode_nxt  = mode_r;
      flag_nxt  = flag_r;
      bod_nxt   = bod_r;
      wake_nxt  = wake_r;
      rdata_nxt = rdata_r;
      ack_nxt   = (AVS_READ || AVS_WRITE) && !ack_r;
      rst_nxt   = reset_req;
      rpin_nxt  = RESET_PIN;
      if (wr && AVS_BYTEENABLE[0]) begin
         case (AVS_ADDRESS)
            ADDR_MODE:  mode_nxt = AVS_WRITEDATA[6:0];
            ADDR_FLAGS: flag_nxt = flag_r & ~AVS_WRITEDATA[2:0];
            ADDR_BOD:   bod_nxt[7:0] = AVS_WRITEDATA[7:0];
            ADDR_WAKE:  wake_nxt[7:0] = AVS_WRITEDATA[7:0];
            default: ;
         endcase
      end
      if (wr && AVS_BYTEENABLE[1]) begin
         case (AVS_ADDRESS)
            ADDR_BOD:  bod_nxt[11:8] = AVS_WRITEDATA[11:8];
            ADDR_WAKE: wake_nxt[11:8] = AVS_WRITEDATA[11:8];
            default: ;
         endcase
      end
      // Hardware set wins over software clear
      if (fix_evt) begin
         flag_nxt[FLG_FIX] = 1'b1;
      end
      if (sel_evt) begin
         flag_nxt[FLG_SEL] = 1'b1;
      end
      if (WDT_OVERFLOW && wd_run) begin
         flag_nxt[FLG_WDT] = 1'b1;
      end
      if (state_r == ST_IDLE && state_nxt == ST_RUN) begin
         mode_nxt[MODE_IDLE] = 1'b0;
      end
      if (state_r == ST_WAKE && state_nxt == ST_RUN) begin
         mode_nxt[MODE_PD] = 1'b0;
      end
      if (rd) begin
         case (AVS_ADDRESS)
            ADDR_MODE:  rdata_nxt = {25'h0, mode_r};
            ADDR_FLAGS: rdata_nxt = {29'h0, flag_r};
            ADDR_BOD:   rdata_nxt = {20'h0, bod_r};
            ADDR_WAKE:  rdata_nxt = {20'h0, wake_r};
            ADDR_STAT:  rdata_nxt = {30'h0, state_r};
            default:    rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mode_r  <= MODE_RST;
         flag_r  <= 3'h0;
         bod_r   <= BOD_RST;
         wake_r  <= WAKE_RST;
         rdata_r <= 32'h0;
         ack_r   <= 1'b0;
         rst_r   <= 1'b0;
         rpin_r  <= 1'b0;
      end else begin
         mode_r  <= mode_nxt;
         flag_r  <= flag_nxt;
         bod_r   <= bod_nxt;
         wake_r  <= wake_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
         rst_r   <= rst_nxt;
         rpin_r  <= rpin_nxt;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign AVS_READDATA    = rdata_r;
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
   assign CPU_CLK_EN      = (state_r == ST_RUN);
   assign OSC_EN          = (state_r != ST_PD);
   assign FLASH_PWR_EN    = (state_r != ST_PD);
   assign SYSCLK_DIV_SEL  = mode_r[MODE_DIV_L +: 3];
   assign SLOW_MODE       = |mode_r[MODE_DIV_L +: 3];
   assign OSC_SOURCE_SEL  = mode_r[MODE_OSC_L +: 2];
   assign SUBCLK_MODE     = (mode_r[MODE_OSC_L +: 2] == OSC_LOW_RC);
   assign WDT_RUN         = wd_run;
   assign SYS_FLAG_IRQ    = bod_r[BOD_SFIE] &&
                            ((flag_r[FLG_FIX] && bod_r[BOD_FIXIE]) ||
                             (flag_r[FLG_SEL] && bod_r[BOD_SELIE]));
   assign SYS_RESET       = rst_r;

////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_clk_held_wake: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_WAKE) |-> !CPU_CLK_EN) else $error("cpu clock during wake");
   a_pd_osc_off: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_PD) |-> (!OSC_EN && !FLASH_PWR_EN)) else $error("osc on in pd");
   a_pd_stays: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_PD && !wake_any) |=> (state_r == ST_PD))
      else $error("pd left without wake");
   a_pd_wakes: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_PD && wake_any) |=> (state_r == ST_WAKE))
      else $error("wake ignored");
   a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
      sel_evt |=> flag_r[FLG_SEL]) else $error("selectable flag not set");
   a_fix_reset: assert property (@(posedge CORE_CLK) disable iff (RST)
      (fix_evt && bod_r[BOD_FIX_RE]) |=> (SYS_RESET && flag_r[FLG_FIX]))
      else $error("fixed reset missing");
   a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == ADDR_FLAGS && AVS_WRITEDATA[FLG_FIX]
       && !fix_evt) |=> !flag_r[FLG_FIX]) else $error("flag not cleared");
   a_slow_mode: assert property (@(posedge CORE_CLK) disable iff (RST)
      SLOW_MODE == (SYSCLK_DIV_SEL != 3'h0)) else $error("slow mode mismatch");
   a_idle_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_IDLE && CPU_IRQ_PENDING) |=> (state_r == ST_RUN && !mode_r[MODE_IDLE]))
      else $error("idle not ended");
   a_wake_len: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == ST_WAKE && cnt_r != CNT_FULL) |=> (state_r == ST_WAKE && !CPU_CLK_EN))
      else $error("wake too short");

endmodule // pmbc_ctrl

/* verif/testbench.sv */
// Self-checking bench for the power mode and brown-out controller.
// Assumes the Avalon-MM slave inserts one wait cycle and CORE_CLK runs at 25 MHz.
`timescale 1ns/1ns
module testbench;
   import pmbc_pkg::*;
   localparam int TMO = 8;
   typedef struct {logic [6:0] mode; logic [11:0] bod; logic [5:0] vdd;
                   logic [2:0] flg; logic irq;} pmbc_bo_row_t;
   typedef struct {logic [11:0] wake; logic [11:0] bod; int kind;
                   logic ok; logic wrun;} pmbc_pd_row_t;
   logic        CORE_CLK = 1'b0, RST = 1'b1;
   logic [4:0]  AVS_ADDRESS = 5'h00;
   logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic [5:0]  VDD_LEVEL = 6'h32;
   logic [3:0]  EXT_IRQ = 4'hB;
   logic        KEYPAD_MATCH = 1'b0, RESET_PIN = 1'b0, WDT_OVERFLOW = 1'b0;
   logic        CPU_IRQ_PENDING = 1'b0;
   logic        CPU_CLK_EN, OSC_EN, FLASH_PWR_EN, SLOW_MODE, SUBCLK_MODE, WDT_RUN;
   logic        SYS_FLAG_IRQ, SYS_RESET;
   logic [2:0]  SYSCLK_DIV_SEL;
   logic [1:0]  OSC_SOURCE_SEL;
   int          num_errors = 0, n_checks = 0;
   logic [31:0] q;
   pmbc_bo_row_t bo_rows[8] = '{
      '{7'h00, 12'h004, 6'h14, 3'b110, 1'b0}, '{7'h04, 12'h614, 6'h18, 3'b100, 1'b0},
      '{7'h1C, 12'hA24, 6'h25, 3'b100, 1'b1}, '{7'h20, 12'h834, 6'h2A, 3'b100, 1'b0},
      '{7'h3C, 12'hA34, 6'h2B, 3'b000, 1'b0}, '{7'h40, 12'h600, 6'h16, 3'b010, 1'b1},
      '{7'h68, 12'h400, 6'h16, 3'b010, 1'b0}, '{7'h10, 12'h000, 6'h17, 3'b000, 1'b0}};
   pmbc_pd_row_t pd_rows[9] = '{
      '{12'h001, 12'h000, 0, 1'b1, 1'b0}, '{12'h404, 12'h000, 1, 1'b1, 1'b0},
      '{12'h010, 12'h000, 2, 1'b1, 1'b0}, '{12'h000, 12'h000, 2, 1'b0, 1'b0},
      '{12'h000, 12'h000, 3, 1'b1, 1'b0}, '{12'h060, 12'h000, 4, 1'b1, 1'b1},
      '{12'h020, 12'h000, 4, 1'b0, 1'b0}, '{12'h000, 12'hB04, 5, 1'b1, 1'b0},
      '{12'h000, 12'hA04, 5, 1'b0, 1'b0}};

   pmbc_ctrl #(.WAKE_TMO(TMO)) dut (
      .CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .VDD_LEVEL(VDD_LEVEL), .EXT_IRQ(EXT_IRQ), .EXT_IRQ_EDGE(4'h0),
      .KEYPAD_MATCH(KEYPAD_MATCH), .RESET_PIN(RESET_PIN), .WDT_OVERFLOW(WDT_OVERFLOW),
      .CPU_IRQ_PENDING(CPU_IRQ_PENDING), .CPU_CLK_EN(CPU_CLK_EN), .OSC_EN(OSC_EN),
      .FLASH_PWR_EN(FLASH_PWR_EN), .SLOW_MODE(SLOW_MODE), .SUBCLK_MODE(SUBCLK_MODE),
      .SYSCLK_DIV_SEL(SYSCLK_DIV_SEL), .OSC_SOURCE_SEL(OSC_SOURCE_SEL),
      .WDT_RUN(WDT_RUN), .SYS_FLAG_IRQ(SYS_FLAG_IRQ), .SYS_RESET(SYS_RESET));

   initial begin
      forever #20 CORE_CLK = ~CORE_CLK;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // One Avalon cycle: hold the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
      int n;
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= d;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
      rq = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      if (n >= 50) chk(1'b0, 1'b1, "bus answer missing");
   endtask

   // Drive one wake stimulus to its active or idle level
   task automatic apply(input int kind, input logic on);
      case (kind)
         0: EXT_IRQ[0] <= !on;
         1: EXT_IRQ[2] <= on;
         2: KEYPAD_MATCH <= on;
         3: RESET_PIN <= on;
         4: WDT_OVERFLOW <= on;
         default: VDD_LEVEL <= on ? 6'h10 : 6'h32;
      endcase
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #400000;
      num_errors++;
      complete_run;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(negedge CORE_CLK);
      chk({CPU_CLK_EN, OSC_EN, SYS_RESET}, 3'b110, "outputs after reset");
      foreach (bo_rows[i]) begin
         bus(1, ADDR_MODE, {25'h0, bo_rows[i].mode}, q);
         bus(1, ADDR_BOD, {20'h0, bo_rows[i].bod}, q);
         @(posedge CORE_CLK);
         VDD_LEVEL <= bo_rows[i].vdd;
         repeat (3) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk({SUBCLK_MODE, SLOW_MODE, OSC_SOURCE_SEL, SYSCLK_DIV_SEL},
             {bo_rows[i].mode[6:5] == OSC_LOW_RC, bo_rows[i].mode[4:2] != 3'h0,
              bo_rows[i].mode[6:2]}, "clock mode outputs");
         chk(SYS_FLAG_IRQ, bo_rows[i].irq, "flag interrupt");
         bus(0, ADDR_FLAGS, 32'h0, q);
         chk(q[2:0], bo_rows[i].flg, "brown-out flags");
         @(posedge CORE_CLK);
         VDD_LEVEL <= 6'h32;
         bus(1, ADDR_FLAGS, 32'h0, q);
         bus(0, ADDR_FLAGS, 32'h0, q);
         chk(q[2:0], bo_rows[i].flg, "flags after zero write");
         bus(1, ADDR_FLAGS, 32'h7, q);
         bus(0, ADDR_FLAGS, 32'h0, q);
         chk(q[2:0], 3'b000, "flags after one write");
      end
      bus(1, ADDR_MODE, 32'h0, q);
      // Detector reset requests, fixed then selectable
      for (int i = 0; i < 2; i++) begin
         bus(1, ADDR_BOD, (i == 0) ? 32'h002 : 32'h00C, q);
         @(posedge CORE_CLK);
         VDD_LEVEL <= (i == 0) ? 6'h16 : 6'h14;
         repeat (3) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk(SYS_RESET, 1'b1, "brown-out reset");
         @(posedge CORE_CLK);
         VDD_LEVEL <= 6'h32;
         repeat (3) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk(SYS_RESET, 1'b0, "reset released");
         bus(0, ADDR_FLAGS, 32'h0, q);
         chk(q[i + 1], 1'b1, "reset cause flag");
         bus(1, ADDR_BOD, 32'h0, q);
         bus(1, ADDR_FLAGS, 32'h7, q);
      end
      // Idle: clock stops, detector still active, interrupt ends it
      bus(1, ADDR_MODE, 32'h1, q);
      @(posedge CORE_CLK);
      VDD_LEVEL <= 6'h16;
      repeat (3) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      chk({CPU_CLK_EN, OSC_EN}, 2'b01, "idle clocks");
      bus(0, ADDR_STAT, 32'h0, q);
      chk(q[1:0], ST_IDLE, "idle state");
      bus(0, ADDR_FLAGS, 32'h0, q);
      chk(q[1], 1'b1, "detector during idle");
      @(posedge CORE_CLK);
      CPU_IRQ_PENDING <= 1'b1;
      VDD_LEVEL <= 6'h32;
      repeat (3) @(posedge CORE_CLK);
      CPU_IRQ_PENDING <= 1'b0;
      @(negedge CORE_CLK);
      chk(CPU_CLK_EN, 1'b1, "idle ended");
      bus(0, ADDR_MODE, 32'h0, q);
      chk(q[1:0], 2'b00, "idle bit cleared");
      bus(1, ADDR_FLAGS, 32'h7, q);
      // Power-down wake sources
      foreach (pd_rows[i]) begin
         bus(1, ADDR_WAKE, {20'h0, pd_rows[i].wake}, q);
         bus(1, ADDR_BOD, {20'h0, pd_rows[i].bod}, q);
         repeat (100) @(posedge CORE_CLK);
         bus(1, ADDR_MODE, 32'h2, q);
         repeat (2) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk({CPU_CLK_EN, OSC_EN, FLASH_PWR_EN}, 3'b000, "power-down outputs");
         chk(WDT_RUN, pd_rows[i].wrun, "watchdog in power-down");
         @(posedge CORE_CLK);
         apply(pd_rows[i].kind, 1'b1);
         @(posedge CORE_CLK);
         if (pd_rows[i].kind == 4) WDT_OVERFLOW <= 1'b0;
         repeat (TMO - 3) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk({CPU_CLK_EN, OSC_EN}, {1'b0, pd_rows[i].ok}, "timed restart");
         repeat (8) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk(CPU_CLK_EN, pd_rows[i].ok, "wake decision");
         @(posedge CORE_CLK);
         if (!pd_rows[i].ok) RESET_PIN <= 1'b1;
         repeat (TMO + 6) @(posedge CORE_CLK);
         apply(pd_rows[i].kind, 1'b0);
         if (pd_rows[i].kind != 3) RESET_PIN <= 1'b0;
         repeat (4) @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         chk(CPU_CLK_EN, 1'b1, "running after wake");
         bus(0, ADDR_MODE, 32'h0, q);
         chk(q[1:0], 2'b00, "power-down bit cleared");
         bus(0, ADDR_FLAGS, 32'h0, q);
         if (pd_rows[i].kind == 4 && pd_rows[i].ok) chk(q[0], 1'b1, "watchdog flag");
         bus(1, ADDR_WAKE, 32'h0, q);
         bus(1, ADDR_BOD, 32'h0, q);
         bus(1, ADDR_FLAGS, 32'h7, q);
      end
      // Reset in mid power-down returns everything to reset values
      bus(1, ADDR_WAKE, 32'h0E0, q);
      bus(1, ADDR_BOD, 32'hF0E, q);
      repeat (100) @(posedge CORE_CLK);
      bus(1, ADDR_MODE, 32'h7E, q);
      @(posedge CORE_CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(negedge CORE_CLK);
      chk({CPU_CLK_EN, OSC_EN, FLASH_PWR_EN, SYS_RESET}, 4'b1110, "outputs after reset");
      for (int a = 0; a < 5; a++) begin
         bus(0, 5'(a * 4), 32'h0, q);
         chk(q, 32'h0, "register after reset");
      end
      bus(0, 5'h14, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      complete_run;
   end
endmodule // testbench
